/* src/cpu_input_ports_irq_vector.sv */
// Processor input ports: acknowledge, restart vector, status port,
// interrupt request, wait and power-up reset.
// Assumes processor strobes arrive synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module cpu_input_ports_irq_vector #(
  parameter int RESET_CYCLES = cpu_ports_pkg::RESET_HOLD_CYCLES
) (
  input  wire logic                                 clock,
  input  wire logic                                 resetn,
  input  wire logic                                 io_request_n,
  input  wire logic                                 opcode_fetch_cycle_n,
  input  wire logic                                 status_port_select_n,
  input  wire logic                                 scan_irq_indicator,
  input  wire logic                                 scan_tick,
  input  wire logic                                 timer_tick,
  input  wire logic                                 serial_event,
  input  wire logic                                 display_access_req,
  input  wire logic                                 memory_window_open,
  input  wire logic                                 vertical_drive,
  input  wire logic                                 odd_field_flag,
  input  wire logic                                 mains_rate_jumper_n,
  input  wire logic [cpu_ports_pkg::ADDR_WIDTH-1:0] terminal_addr_jumpers,
  input  wire logic [cpu_ports_pkg::DATA_WIDTH-1:0] cpu_data_bus_in,
  output logic      [cpu_ports_pkg::DATA_WIDTH-1:0] cpu_data_bus_out,
  output logic                                      cpu_data_bus_oe,
  output logic                                      irq_ack_strobe,
  output logic                                      irq_n,
  output logic                                      wait_n,
  output logic                                      cpu_reset_n,
  output logic                                      t_state_en
);
  import cpu_ports_pkg::*;

  por_link_if link ();

  por_timer #(.RESET_CYCLES(RESET_CYCLES)) u_por (
    .clock  (clock),
    .resetn (resetn),
    .link   (link.src)
  );

  logic                  ack_q;
  logic                  pend_q;
  logic                  wait_q;
  logic                  rst_q;
  logic                  ten_q;
  logic [DATA_WIDTH-1:0] dout_q;
  logic                  oe_q;
  logic                  ack_now;
  logic                  sel_now;
  logic                  irq_event;

  function automatic logic [DATA_WIDTH-1:0] status_byte(
    input logic                  vdrv,
    input logic                  odd,
    input logic                  mains_n,
    input logic [ADDR_WIDTH-1:0] addr
  );
    logic [DATA_WIDTH-1:0] b;
    b = DATA_RESET;
    b[STATUS_ADDR_LSB +: ADDR_WIDTH] = addr;
    b[STATUS_VDRIVE_BIT] = vdrv;
    b[STATUS_ODD_BIT]    = odd;
    b[STATUS_MAINS_BIT]  = mains_n;
    return b;
  endfunction : status_byte

  assign ack_now   = !io_request_n && !opcode_fetch_cycle_n;
  assign sel_now   = !status_port_select_n && !ack_now;
  assign irq_event = scan_tick || timer_tick || serial_event;

  // Acknowledge strobe
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_now;
    end
  end

  // Interrupt pending; a new event wins over the acknowledge clear
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pend_q <= 1'b0;
    end else if (irq_event) begin
      pend_q <= 1'b1;
    end else if (ack_now) begin
      pend_q <= 1'b0;
    end
  end

  // Data bus: vector on acknowledge, status on select, else released
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dout_q <= DATA_RESET;
      oe_q   <= 1'b0;
    end else if (ack_now) begin
      dout_q <= scan_irq_indicator ? VECTOR_SCAN : VECTOR_TIMER;
      oe_q   <= 1'b1;
    end else if (sel_now) begin
      dout_q <= status_byte(vertical_drive, odd_field_flag,
                            mains_rate_jumper_n,
                            terminal_addr_jumpers);
      oe_q   <= 1'b1;
    end else begin
      oe_q   <= 1'b0;
    end
  end

  // Wait during restricted display memory periods
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= display_access_req && !memory_window_open;
    end
  end

  // Reset and clock enable outputs
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_q <= 1'b0;
      ten_q <= 1'b0;
    end else begin
      rst_q <= link.por_done;
      ten_q <= link.t_state_en;
    end
  end

  assign irq_ack_strobe   = ack_q;
  assign irq_n            = !pend_q;
  assign wait_n           = !wait_q;
  assign cpu_reset_n      = rst_q;
  assign t_state_en       = ten_q;
  assign cpu_data_bus_out = dout_q;
  assign cpu_data_bus_oe  = oe_q;

  property p_ack;
    @(posedge clock) disable iff (!resetn)
      (!io_request_n && !opcode_fetch_cycle_n) |=> irq_ack_strobe;
  endproperty
  a_ack: assert property (p_ack)
    else $error("acknowledge strobe missing");

  property p_vec_scan;
    @(posedge clock) disable iff (!resetn)
      (ack_now && scan_irq_indicator) |=>
        (cpu_data_bus_oe && cpu_data_bus_out == 8'hFF);
  endproperty
  a_vec_scan: assert property (p_vec_scan)
    else $error("scan vector wrong");

  property p_vec_timer;
    @(posedge clock) disable iff (!resetn)
      (ack_now && !scan_irq_indicator) |=>
        (cpu_data_bus_oe && cpu_data_bus_out == 8'hCF);
  endproperty
  a_vec_timer: assert property (p_vec_timer)
    else $error("timer vector wrong");

  property p_irq;
    @(posedge clock) disable iff (!resetn)
      scan_tick |=> !irq_n;
  endproperty
  a_irq: assert property (p_irq)
    else $error("scan tick gave no interrupt");

  property p_irq_hold;
    @(posedge clock) disable iff (!resetn)
      (!irq_n && !ack_now) |=> !irq_n;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt dropped before acknowledge");

  property p_wait;
    @(posedge clock) disable iff (!resetn)
      (display_access_req && !memory_window_open) |=> !wait_n;
  endproperty
  a_wait: assert property (p_wait)
    else $error("wait not asserted");

  property p_status;
    @(posedge clock) disable iff (!resetn)
      sel_now |=> (cpu_data_bus_oe
        && cpu_data_bus_out[5] == $past(vertical_drive)
        && cpu_data_bus_out[6] == $past(odd_field_flag)
        && cpu_data_bus_out[7] == $past(mains_rate_jumper_n)
        && cpu_data_bus_out[4:0] == $past(terminal_addr_jumpers));
  endproperty
  a_status: assert property (p_status)
    else $error("status byte wrong");

  property p_release;
    @(posedge clock) disable iff (!resetn)
      (status_port_select_n && !ack_now) |=> !cpu_data_bus_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("bus driven while idle");

  property p_ack_idle;
    @(posedge clock) disable iff (!resetn)
      !(!io_request_n && !opcode_fetch_cycle_n) |=> !irq_ack_strobe;
  endproperty
  a_ack_idle: assert property (p_ack_idle)
    else $error("acknowledge strobe without request");

  property p_irq_clear;
    @(posedge clock) disable iff (!resetn)
      (ack_now && !irq_event) |=> irq_n;
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("interrupt not cleared by acknowledge");

  property p_irq_keep;
    @(posedge clock) disable iff (!resetn)
      (ack_now && irq_event) |=> !irq_n;
  endproperty
  a_irq_keep: assert property (p_irq_keep)
    else $error("new event lost in acknowledge cycle");

  c_scan_ack: cover property (@(posedge clock) disable iff (!resetn)
    ack_now && scan_irq_indicator);
  c_timer_ack: cover property (@(posedge clock) disable iff (!resetn)
    ack_now && !scan_irq_indicator);
  c_status: cover property (@(posedge clock) disable iff (!resetn)
    sel_now);
  c_reset_out: cover property (@(posedge clock) disable iff (!resetn)
    $rose(cpu_reset_n));
endmodule : cpu_input_ports_irq_vector
`default_nettype wire

/* src/cpu_ports_pkg.sv */
// Constants shared by the processor input-port block and its reset timer.
// Assumes a single 100 MHz clock and an active-low asynchronous reset.
// Operation
// - Acknowledge strobe is the AND of active I/O request and opcode fetch.
// - On acknowledge, latch inputs and drive vector FF when scan indicator set.
// - On acknowledge without scan indicator, drive vector CF for a timer.
// - Interrupt request asserts for scan ends, timer ticks or serial-line service.
// - Wait holds the processor off display memory in restricted periods.
// - Selected status port reports the vertical drive signal.
// - Status port reports the odd/even interlace field flag.
// - Status port reports the mains-rate jumper, installed meaning 60 Hz.
// - Status port shows five address jumpers; address 1F means broadcast.
// - Processor reset stays low 50 us after power-up.
// - Processor runs on a 4.00 MHz clock, 0.25 us per T-state.
// - Data moves over an 8-bit bidirectional data bus.
// - Every scan tick raises a processor interrupt, once per 64 us.
package cpu_ports_pkg;
  localparam int CLOCK_MHZ         = 100;
  localparam int RESET_HOLD_US     = 50;
  localparam int RESET_HOLD_CYCLES = RESET_HOLD_US * CLOCK_MHZ;
  localparam int CPU_CLOCK_KHZ     = 4000;
  localparam int T_STATE_CYCLES    = (CLOCK_MHZ * 1000) / CPU_CLOCK_KHZ;
  localparam int SCAN_TICK_US      = 64;
  localparam int DATA_WIDTH        = 8;
  localparam int ADDR_WIDTH        = 5;
  localparam logic [7:0] VECTOR_SCAN  = 8'hFF;
  localparam logic [7:0] VECTOR_TIMER = 8'hCF;
  localparam logic [4:0] BROADCAST_ADDR = 5'h1F;
  localparam int STATUS_ADDR_LSB   = 0;
  localparam int STATUS_VDRIVE_BIT = 5;
  localparam int STATUS_ODD_BIT    = 6;
  localparam int STATUS_MAINS_BIT  = 7;
  localparam logic [7:0] DATA_RESET = 8'h00;
endpackage : cpu_ports_pkg

/* src/por_link_if.sv */
// Carries power-up reset and T-state enable from the timer to the top.
// Assumes both ends share the system clock.
`timescale 1ns/1ps
`default_nettype none
interface por_link_if;
  logic por_done;
  logic t_state_en;
  modport src (output por_done, output t_state_en);
  modport dst (input por_done, input t_state_en);
endinterface : por_link_if
`default_nettype wire

/* src/por_timer.sv */
// Power-up reset stretcher and processor T-state enable divider.
// Assumes resetn is the raw power-on reset.
`timescale 1ns/1ps
`default_nettype none
module por_timer #(
  parameter int RESET_CYCLES = cpu_ports_pkg::RESET_HOLD_CYCLES
) (
  input  wire logic clock,
  input  wire logic resetn,
  por_link_if.src   link
);
  import cpu_ports_pkg::*;

  logic [15:0] hold_q;
  logic [7:0]  div_q;
  logic        done_q;
  logic        en_q;

  // Reset hold counter
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hold_q <= 16'h0000;
      done_q <= 1'b0;
    end else if (hold_q != 16'(RESET_CYCLES - 1)) begin
      hold_q <= hold_q + 16'h0001;
    end else begin
      done_q <= 1'b1;
    end
  end

  // T-state enable pulse
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div_q <= 8'h00;
      en_q  <= 1'b0;
    end else if (div_q == 8'(T_STATE_CYCLES - 1)) begin
      div_q <= 8'h00;
      en_q  <= 1'b1;
    end else begin
      div_q <= div_q + 8'h01;
      en_q  <= 1'b0;
    end
  end

  assign link.por_done   = done_q;
  assign link.t_state_en = en_q;

  property p_reset_hold;
    @(posedge clock) disable iff (!resetn)
      (hold_q < 16'(RESET_CYCLES - 1)) |-> !done_q;
  endproperty
  a_reset_hold: assert property (p_reset_hold)
    else $error("reset released early");

  property p_t_state;
    @(posedge clock) disable iff (!resetn)
      en_q |=> (!en_q) [*8];
  endproperty
  a_t_state: assert property (p_t_state)
    else $error("T-state enable too frequent");
endmodule : por_timer
`default_nettype wire

/* tb/cpu_core_model.sv */
// Processor model: acknowledge and status-read cycles on the bus.
// Assumes the bench steps it; strobes change on falling edges.
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  input  wire logic       clock,
  input  wire logic       wait_n,
  input  wire logic       oe,
  input  wire logic       ack,
  input  wire logic [7:0] bus,
  output logic            io_request_n,
  output logic            opcode_fetch_cycle_n,
  output logic            status_port_select_n
);
  initial begin
    io_request_n         = 1'b1;
    opcode_fetch_cycle_n = 1'b1;
    status_port_select_n = 1'b1;
  end
  // Kind 1 acknowledges an interrupt, kind 0 reads status
  task automatic cycle(input bit kind, output logic [7:0] v,
                       output logic a);
    int n;
    n = 0;
    while (wait_n !== 1'b1) @(negedge clock);
    if (kind) begin
      io_request_n         = 1'b0;
      opcode_fetch_cycle_n = 1'b0;
    end else begin
      status_port_select_n = 1'b0;
    end
    do begin
      @(negedge clock);
      n++;
    end while (oe !== 1'b1 && n < 8);
    v = bus;
    a = ack;
    io_request_n         = 1'b1;
    opcode_fetch_cycle_n = 1'b1;
    status_port_select_n = 1'b1;
    @(negedge clock);
  endtask : cycle
endmodule : cpu_core_model
`default_nettype wire

/* tb/cpu_input_ports_irq_vector_test.sv */
// Bench for the processor input ports block.
// Assumes the processor model above; the released bus reads inverted.
`timescale 1ns/1ps
`default_nettype none
module cpu_input_ports_irq_vector_test;
  import cpu_ports_pkg::*;
  localparam int RC = 20;
  logic       clock, resetn, rq_n, m1_n, sel_n, ind, stk, ttk, sev;
  logic       dreq, wopen, vd, odd, mns_n, oe, ack, irq_n, wait_n;
  logic       rst_n, ten;
  logic [4:0] addr;
  logic [7:0] dout, bus, last_q, v;
  logic       a;
  int         fail_count, samples_checked;
  assign bus = oe ? dout : ~last_q;
  always @(posedge clock) if (oe) last_q <= dout;
  cpu_input_ports_irq_vector #(.RESET_CYCLES(RC)) dut (
    .clock(clock), .resetn(resetn), .io_request_n(rq_n),
    .opcode_fetch_cycle_n(m1_n), .status_port_select_n(sel_n),
    .scan_irq_indicator(ind), .scan_tick(stk), .timer_tick(ttk),
    .serial_event(sev), .display_access_req(dreq),
    .memory_window_open(wopen), .vertical_drive(vd),
    .odd_field_flag(odd), .mains_rate_jumper_n(mns_n),
    .terminal_addr_jumpers(addr), .cpu_data_bus_in(bus),
    .cpu_data_bus_out(dout), .cpu_data_bus_oe(oe),
    .irq_ack_strobe(ack), .irq_n(irq_n), .wait_n(wait_n),
    .cpu_reset_n(rst_n), .t_state_en(ten));
  cpu_core_model cpu (.clock(clock), .wait_n(wait_n), .oe(oe),
    .ack(ack), .bus(bus), .io_request_n(rq_n),
    .opcode_fetch_cycle_n(m1_n), .status_port_select_n(sel_n));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic check_byte(input logic [7:0] got, input logic [7:0] e);
    samples_checked++;
    if (got !== e) begin
      fail_count++;
      $display("MISMATCH %0t byte %h expected %h", $time, got, e);
    end
  endtask : check_byte
  task automatic check_bit(input logic got, input logic e);
    check_byte({7'h00, got}, {7'h00, e});
  endtask : check_bit
  task automatic report_and_stop();
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic t_reset();
    int n;
    n = 0;
    check_bit(rst_n, 1'b0);
    check_bit(oe, 1'b0);
    check_bit(irq_n, 1'b1);
    check_bit(wait_n, 1'b1);
    check_bit(ack, 1'b0);
    check_bit(ten, 1'b0);
    resetn = 1'b1;
    while (rst_n !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    check_byte(8'(n), 8'(RC + 1));
    n = 0;
    while (ten !== 1'b1 && n < 60) begin
      @(negedge clock);
      n++;
    end
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (ten !== 1'b1 && n < 60);
    check_byte(8'(n), 8'(T_STATE_CYCLES));
    $display("test reset done");
  endtask : t_reset
  task automatic t_vec(input bit scan, input int src);
    ind = scan;
    stk = (src == 0);
    ttk = (src == 1);
    sev = (src == 2);
    @(negedge clock);
    {stk, ttk, sev} = 3'b000;
    check_bit(irq_n, 1'b0);
    cpu.cycle(1'b1, v, a);
    check_byte(v, scan ? 8'hFF : 8'hCF);
    check_bit(a, 1'b1);
    repeat (2) @(negedge clock);
    check_bit(irq_n, 1'b1);
    check_bit(oe, 1'b0);
    check_bit(ack, 1'b0);
    $display("test vector %0d done", src);
  endtask : t_vec
  task automatic t_status();
    logic [7:0] tbl [4];
    logic [7:0] e;
    tbl = '{8'h9E, 8'h61, 8'h25, 8'hC0};
    foreach (tbl[i]) begin
      {mns_n, odd, vd, addr} = tbl[i];
      e = 8'h00;
      e[STATUS_MAINS_BIT] = mns_n;
      e[STATUS_ODD_BIT] = odd;
      e[STATUS_VDRIVE_BIT] = vd;
      e[STATUS_ADDR_LSB +: 5] = addr;
      cpu.cycle(1'b0, v, a);
      check_byte(v, e);
    end
    repeat (2) @(negedge clock);
    check_bit(oe, 1'b0);
    $display("test status done");
  endtask : t_status
  task automatic t_wait();
    dreq = 1'b1;
    @(negedge clock);
    check_bit(wait_n, 1'b0);
    wopen = 1'b1;
    @(negedge clock);
    check_bit(wait_n, 1'b1);
    dreq = 1'b0;
    wopen = 1'b0;
    $display("test wait done");
  endtask : t_wait
  task automatic t_ack_event();
    ind = 1'b1;
    stk = 1'b1;
    fork
      cpu.cycle(1'b1, v, a);
      begin
        @(negedge clock);
        stk = 1'b0;
      end
    join
    check_byte(v, VECTOR_SCAN);
    check_bit(irq_n, 1'b0);
    cpu.cycle(1'b1, v, a);
    check_bit(irq_n, 1'b1);
    $display("test event during acknowledge done");
  endtask : t_ack_event
  task automatic t_midreset();
    stk = 1'b1;
    dreq = 1'b1;
    @(negedge clock);
    stk = 1'b0;
    check_bit(irq_n, 1'b0);
    check_bit(wait_n, 1'b0);
    resetn = 1'b0;
    @(negedge clock);
    dreq = 1'b0;
    t_reset();
    $display("test mid-run reset done");
  endtask : t_midreset
  initial begin
    fail_count = 0;
    samples_checked = 0;
    resetn = 1'b0;
    {ind, stk, ttk, sev, dreq, wopen} = 6'h00;
    {mns_n, odd, vd, addr} = 8'h21;
    repeat (5) @(negedge clock);
    t_reset();
    t_vec(1'b1, 0);
    t_vec(1'b0, 1);
    t_vec(1'b0, 2);
    t_status();
    t_wait();
    t_ack_event();
    t_midreset();
    report_and_stop();
  end
  initial begin
    #100000;
    fail_count++;
    report_and_stop();
  end
endmodule : cpu_input_ports_irq_vector_test
`default_nettype wire
